/* File: irq_enable_map_softreset.sv */
// Interrupt enables, pin routing, pin control and soft reset of the motion sensor
`timescale 1ns/10ps
`default_nettype none
module irq_enable_map_softreset
  import irq_map_pkg::*;
#(
  parameter int TICK_CYCLES = HOLD_UNIT_CYCLES,
  parameter int RESET_DELAY_CYCLES = SOFT_RESET_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port from the serial interface
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Detection engine events and configuration
  input wire src_hits_s src_hits,
  output engine_cfg_s engine_cfg_q,
  output logic soft_reset_busy_q,
  // Interrupt pins
  output logic irq_pin_a_o_q,
  output logic irq_pin_a_oe_q,
  output logic irq_pin_b_o_q,
  output logic irq_pin_b_oe_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  generate
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16777216) begin : g_bad_tick
      $error("TICK_CYCLES must be 2 to 16777216");
    end
    if (RESET_DELAY_CYCLES < 1 || RESET_DELAY_CYCLES > 65535) begin : g_bad_delay
      $error("RESET_DELAY_CYCLES must be 1 to 65535");
    end
  endgenerate

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [15:0] DELAY_LAST = 16'(RESET_DELAY_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] en0_q;
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic [7:0] map_a_q;
  logic [7:0] map_s_q;
  logic [7:0] pin_ctrl_q;
  logic [7:0] latch_ctrl_q;
  logic [15:0] delay_q;
  logic reset_fire;
  logic key_write;
  logic clear_pulse;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // Only the exact key counts; any other value is dropped without effect
  assign key_write = reg_wr_en && hit(reg_addr, ADDR_SOFT_RESET)
                     && (reg_wdata == SOFT_RESET_KEY);
  assign reset_fire = soft_reset_busy_q && (delay_q == 16'h0000);
  // Write of the clear bit is a pulse; the bit itself is never stored
  assign clear_pulse = reg_wr_en && hit(reg_addr, ADDR_LATCH_CTRL)
                       && reg_wdata[LCTL_CLEAR];

  // Soft reset delay; a second key write while pending restarts the wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_busy_q <= 1'b0;
      delay_q <= 16'h0000;
    end else if (key_write) begin
      soft_reset_busy_q <= 1'b1;
      delay_q <= DELAY_LAST;
    end else if (reset_fire) begin
      soft_reset_busy_q <= 1'b0;
    end else if (soft_reset_busy_q) begin
      delay_q <= delay_q - 16'h0001;
    end
  end

  // Configuration registers; soft reset takes priority over a same-cycle write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en0_q <= RST_ENABLE;
      en1_q <= RST_ENABLE;
      en2_q <= RST_ENABLE;
      map_a_q <= RST_MAP;
      map_s_q <= RST_MAP;
      pin_ctrl_q <= RST_PIN_CTRL;
      latch_ctrl_q <= RST_LATCH_CTRL;
    end else if (reset_fire) begin
      en0_q <= RST_ENABLE;
      en1_q <= RST_ENABLE;
      en2_q <= RST_ENABLE;
      map_a_q <= RST_MAP;
      map_s_q <= RST_MAP;
      pin_ctrl_q <= RST_PIN_CTRL;
      latch_ctrl_q <= RST_LATCH_CTRL;
    end else if (reg_wr_en) begin
      // Reserved bits are masked so they always read back zero
      case (reg_addr)
        ADDR_EN_GROUP0: en0_q <= reg_wdata & MASK_EN_GROUP0;
        ADDR_EN_GROUP1: en1_q <= reg_wdata & MASK_EN_GROUP1;
        ADDR_EN_GROUP2: en2_q <= reg_wdata & MASK_EN_GROUP2;
        ADDR_PIN_A_MAP: map_a_q <= reg_wdata;
        ADDR_SHARED_MAP: map_s_q <= reg_wdata & MASK_SHARED_MAP;
        ADDR_PIN_CTRL: pin_ctrl_q <= reg_wdata & MASK_PIN_CTRL;
        ADDR_LATCH_CTRL: latch_ctrl_q <= reg_wdata & MASK_LATCH_CTRL;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Read data valid one cycle after the strobe; unmapped and write-only read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          ADDR_SOFT_RESET: reg_rdata_q <= RST_SOFT_RESET;
          ADDR_EN_GROUP0: reg_rdata_q <= en0_q;
          ADDR_EN_GROUP1: reg_rdata_q <= en1_q;
          ADDR_EN_GROUP2: reg_rdata_q <= en2_q;
          ADDR_PIN_A_MAP: reg_rdata_q <= map_a_q;
          ADDR_SHARED_MAP: reg_rdata_q <= map_s_q;
          ADDR_PIN_CTRL: reg_rdata_q <= pin_ctrl_q;
          ADDR_LATCH_CTRL: reg_rdata_q <= latch_ctrl_q;
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine configuration out

  // Engines see the enables registered, so they change one cycle after a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_cfg_q <= '0;
    end else begin
      engine_cfg_q.level_pose <= en0_q[EN0_LEVEL_POSE];
      engine_cfg_q.pose_change <= en0_q[EN0_POSE_CHANGE];
      engine_cfg_q.one_knock <= en0_q[EN0_ONE_KNOCK];
      engine_cfg_q.two_knock <= en0_q[EN0_TWO_KNOCK];
      engine_cfg_q.gradient_axes <= en0_q[AXIS_LSB +: 3];
      engine_cfg_q.queue_mark <= en1_q[EN1_QUEUE_MARK];
      engine_cfg_q.queue_full <= en1_q[EN1_QUEUE_FULL];
      engine_cfg_q.fresh_sample <= en1_q[EN1_FRESH_SAMPLE];
      engine_cfg_q.freefall <= en1_q[EN1_FREEFALL];
      engine_cfg_q.shock_axes <= en1_q[AXIS_LSB +: 3];
      engine_cfg_q.still_no_motion <= en2_q[EN2_STILL_SEL];
      engine_cfg_q.stillness_axes <= en2_q[AXIS_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating and routing

  logic [NUM_SRC-1:0] gated;
  logic [NUM_SRC-1:0] route_a;
  logic [NUM_SRC-1:0] route_b;
  logic [1:0] raw_pin;

  // Source order: pin A map bits 7..0, then queue mark, queue full, fresh sample
  always_comb begin
    gated[10] = src_hits.level_pose & en0_q[EN0_LEVEL_POSE];
    gated[9] = src_hits.pose_change & en0_q[EN0_POSE_CHANGE];
    gated[8] = src_hits.one_knock & en0_q[EN0_ONE_KNOCK];
    gated[7] = src_hits.two_knock & en0_q[EN0_TWO_KNOCK];
    // Axis sources fire on any enabled axis, then share one map bit
    gated[6] = |(src_hits.stillness_axes & en2_q[AXIS_LSB +: 3]);
    gated[5] = |(src_hits.gradient_axes & en0_q[AXIS_LSB +: 3]);
    gated[4] = |(src_hits.shock_axes & en1_q[AXIS_LSB +: 3]);
    gated[3] = src_hits.freefall & en1_q[EN1_FREEFALL];
    gated[2] = src_hits.queue_mark & en1_q[EN1_QUEUE_MARK];
    gated[1] = src_hits.queue_full & en1_q[EN1_QUEUE_FULL];
    gated[0] = src_hits.fresh_sample & en1_q[EN1_FRESH_SAMPLE];
  end

  // A queue source may be routed to both pins at once; the other sources reach pin A only
  assign route_a = {map_a_q, map_s_q[SMAP_A_MARK], map_s_q[SMAP_A_FULL],
                    map_s_q[SMAP_A_FRESH]};
  assign route_b = {8'h00, map_s_q[SMAP_B_MARK], map_s_q[SMAP_B_FULL],
                    map_s_q[SMAP_B_FRESH]};
  assign raw_pin[0] = |(gated & route_a);
  assign raw_pin[1] = |(gated & route_b);

  ////////////////////////////////////////////////////////////////////////////
  // Hold timing and pin drivers

  logic [23:0] tick_cnt_q;
  logic unit_tick;
  logic [1:0] held;
  logic [1:0] level_bit;
  logic [1:0] drain_bit;
  logic [1:0] pin_level;
  hold_mode_e mode;
  logic [15:0] hold_len;

  // One shared divider; a timed hold may end up to one unit early for that reason
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 24'h000000;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end
  assign unit_tick = (tick_cnt_q == TICK_LAST);

  assign mode = hold_mode(latch_ctrl_q[3:0]);
  assign hold_len = hold_units(latch_ctrl_q[3:0]);
  assign level_bit = {pin_ctrl_q[PCTL_B_LEVEL], pin_ctrl_q[PCTL_A_LEVEL]};
  assign drain_bit = {pin_ctrl_q[PCTL_B_DRAIN], pin_ctrl_q[PCTL_A_DRAIN]};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      irq_hold_unit u_hold (
        .clk(clk),
        .rst_n(rst_n),
        .unit_tick(unit_tick),
        .clear(clear_pulse | reset_fire),
        .mode(mode),
        .hold_len(hold_len),
        .raw(raw_pin[p]),
        .active_q(held[p])
      );
      // Electrical level: active high when level bit set
      assign pin_level[p] = ~(held[p] ^ level_bit[p]);
    end
  endgenerate

  // Open drain only pulls low; push-pull always drives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_a_o_q <= 1'b0;
      irq_pin_a_oe_q <= 1'b0;
      irq_pin_b_o_q <= 1'b0;
      irq_pin_b_oe_q <= 1'b0;
    end else begin
      irq_pin_a_o_q <= drain_bit[0] ? 1'b0 : pin_level[0];
      irq_pin_a_oe_q <= drain_bit[0] ? ~pin_level[0] : 1'b1;
      irq_pin_b_o_q <= drain_bit[1] ? 1'b0 : pin_level[1];
      irq_pin_b_oe_q <= drain_bit[1] ? ~pin_level[1] : 1'b1;
    end
  end

endmodule // irq_enable_map_softreset
`default_nettype wire

/* File: irq_enable_map_softreset_chk.sv */
// Assertion checker for the interrupt enable, routing and soft-reset block
`timescale 1ns/10ps
`default_nettype none
module irq_enable_map_softreset_chk
  import irq_map_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int RESET_DELAY_CYCLES = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Status and pins
  input wire engine_cfg_s engine_cfg_q,
  input wire logic soft_reset_busy_q,
  input wire logic irq_pin_a_o_q,
  input wire logic irq_pin_a_oe_q,
  input wire logic irq_pin_b_o_q,
  input wire logic irq_pin_b_oe_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic key_w;
  logic [15:0] busy_n_q;
  assign key_w = reg_wr_en && reg_addr == ADDR_SOFT_RESET && reg_wdata == SOFT_RESET_KEY;
  // Busy length; a repeated key restarts the delay, so the count restarts too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_n_q <= 16'h0000;
    end else if (key_w || !soft_reset_busy_q) begin
      busy_n_q <= 16'h0000;
    end else begin
      busy_n_q <= busy_n_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_read_slot: assert property (1'b1 |=> reg_rvalid_q == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");
  a_soft_reads_zero: assert property (
    reg_rd_en && reg_addr == ADDR_SOFT_RESET |=> reg_rdata_q == 8'h00)
    else $error("soft reset register read not zero");
  a_key_sets_busy: assert property (key_w |=> soft_reset_busy_q)
    else $error("key write did not start soft reset");
  a_other_no_busy: assert property (!soft_reset_busy_q && reg_wr_en
    && reg_addr == ADDR_SOFT_RESET && reg_wdata != SOFT_RESET_KEY |=> !soft_reset_busy_q)
    else $error("non-key value started soft reset");
  a_busy_bounded: assert property (
    soft_reset_busy_q |-> busy_n_q < RESET_DELAY_CYCLES)
    else $error("soft reset busy too long");
  a_busy_full_len: assert property (
    $fell(soft_reset_busy_q) |-> $past(busy_n_q) == RESET_DELAY_CYCLES - 1)
    else $error("soft reset ended early");
  a_defaults_back: assert property ($fell(soft_reset_busy_q) && !reg_wr_en
    ##1 !reg_wr_en |-> engine_cfg_q == '0 ##1 (irq_pin_a_oe_q && !irq_pin_a_o_q
    && irq_pin_b_oe_q && !irq_pin_b_o_q))
    else $error("defaults not restored after soft reset");
  a_drive_form: assert property ((!irq_pin_a_oe_q |-> !irq_pin_a_o_q)
    and (!irq_pin_b_oe_q |-> !irq_pin_b_o_q))
    else $error("released pin drives a value");
  // Main scenarios
  c_key: cover property (key_w);
  c_reset_done: cover property ($fell(soft_reset_busy_q));
  c_pin_b_high: cover property (irq_pin_b_oe_q && irq_pin_b_o_q);
endmodule // irq_enable_map_softreset_chk

bind irq_enable_map_softreset irq_enable_map_softreset_chk #(
  .TICK_CYCLES(TICK_CYCLES),
  .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .engine_cfg_q(engine_cfg_q),
  .soft_reset_busy_q(soft_reset_busy_q), .irq_pin_a_o_q(irq_pin_a_o_q),
  .irq_pin_a_oe_q(irq_pin_a_oe_q), .irq_pin_b_o_q(irq_pin_b_o_q),
  .irq_pin_b_oe_q(irq_pin_b_oe_q)
);
`default_nettype wire

/* File: irq_enable_map_softreset_tb.sv */
// Self-checking testbench for the interrupt enable, routing and soft-reset block
`timescale 1ns/10ps
`default_nettype none
module irq_enable_map_softreset_tb
  import irq_map_pkg::*;
;
  localparam int DLY = 3;
  logic clk;
  logic rst_n;
  wire logic wr_en;
  wire logic rd_en;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic rvalid;
  wire logic [1:0] pin_o;
  wire logic [1:0] pin_oe;
  wire logic [1:0] pin_line;
  src_hits_s hits;
  engine_cfg_s cfg;
  logic busy;
  logic [31:0] lfsr;
  int errors;
  int checked;
  int n;
  int rm[int];
  int offs[6] = '{'h16, 'h17, 'h18, 'h19, 'h1A, 'h20};
  int masks[6] = '{'hF7, 'h7F, 'h0F, 'hFF, 'hE7, 'h0F};
  // Short counts keep the run brief
  irq_enable_map_softreset #(.TICK_CYCLES(4), .RESET_DELAY_CYCLES(DLY)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .src_hits(hits),
    .engine_cfg_q(cfg), .soft_reset_busy_q(busy), .irq_pin_a_o_q(pin_o[0]),
    .irq_pin_a_oe_q(pin_oe[0]), .irq_pin_b_o_q(pin_o[1]), .irq_pin_b_oe_q(pin_oe[1]));
  irq_host_model u_host (
    .clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_line(pin_line));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference register file, as after any reset
  task automatic model_defaults();
    rm.delete();
    foreach (offs[i]) rm[offs[i]] = 0;
    rm['h20] = 5;
    rm['h21] = 0;
  endtask
  task automatic wr(input int a, input int d);
    u_host.write_reg(a[7:0], d[7:0]);
    if (rm.exists(a)) rm[a] = (a == 'h21) ? d & 'h0F : d;
  endtask
  task automatic rd_check(input int a);
    logic [7:0] d;
    logic ok;
    u_host.read_reg(a[7:0], d, ok);
    check(ok, 1'b1);
    if (!ok) report_and_stop();
    check(d, rm.exists(a) ? rm[a] : 0);
  endtask
  // Gated OR of mapped sources per pin; per-axis sources count on any enabled axis
  function automatic int raw_exp(input int p, input src_hits_s h);
    int e0;
    int e1;
    int e2;
    int a;
    int b;
    e0 = rm['h16];
    e1 = rm['h17];
    e2 = rm['h18];
    a = rm['h19];
    b = rm['h1A];
    if (p == 1) return (b[7] & e1[4] & h.fresh_sample) | (b[6] & e1[6] & h.queue_mark)
      | (b[5] & e1[5] & h.queue_full);
    return (a[7] & e0[7] & h.level_pose) | (a[6] & e0[6] & h.pose_change)
      | (a[5] & e0[5] & h.one_knock) | (a[4] & e0[4] & h.two_knock)
      | (a[3] & |(e2[2:0] & h.stillness_axes)) | (a[2] & |(e0[2:0] & h.gradient_axes))
      | (a[1] & |(e1[2:0] & h.shock_axes)) | (a[0] & e1[3] & h.freefall)
      | (b[2] & e1[5] & h.queue_full) | (b[1] & e1[6] & h.queue_mark)
      | (b[0] & e1[4] & h.fresh_sample);
  endfunction
  task automatic pin_check(input src_hits_s h);
    int c;
    int lv;
    c = rm['h20];
    for (int p = 0; p < 2; p++) begin
      lv = raw_exp(p, h) ^ int'(!c[2 * p]);
      check({pin_o[p], pin_oe[p], pin_line[p]}, c[2 * p + 1] ? {1'b0, !lv[0], lv[0]}
        : {lv[0], 1'b1, lv[0]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    hits = '0;
    lfsr = 32'h8001;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    model_defaults();
    for (int a = 'h14; a < 'h22; a++) rd_check(a);
    pin_check(hits);
    // Random enables, maps, pin control and events
    for (int k = 0; k < 24; k++) begin
      foreach (offs[i]) begin
        lfsr = next_rand(lfsr);
        wr(offs[i], lfsr[7:0] & masks[i]);
      end
      lfsr = next_rand(lfsr);
      @(posedge clk);
      hits <= lfsr[16:0];
      repeat (3) @(posedge clk);
      #1;
      pin_check(hits);
      check(cfg, {rm['h16][7:4], rm['h16][2:0],
        rm['h17][6:0], rm['h18][3:0]});
      foreach (offs[i]) rd_check(offs[i]);
    end
    // Soft reset: a wrong value is ignored, the key restores defaults after the delay
    wr('h14, 'hB5);
    foreach (offs[i]) rd_check(offs[i]);
    wr('h14, 'hB6);
    model_defaults();
    #1;
    check(busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, DLY);
    if (n >= 50) report_and_stop();
    foreach (offs[i]) rd_check(offs[i]);
    // Latched pulse holds the pin until the clear bit is written
    wr('h16, 'h80);
    wr('h19, 'h80);
    wr('h21, 'h07);
    @(posedge clk);
    hits <= 17'h10000;
    @(posedge clk);
    hits <= '0;
    repeat (5) @(posedge clk);
    #1;
    check({pin_o[0], pin_oe[0]}, 2'b11);
    wr('h21, 'h87);
    repeat (3) @(posedge clk);
    #1;
    check({pin_o[0], pin_oe[0]}, 2'b01);
    // Timed hold of two units outlasts the pulse, then lets the pin go
    wr('h21, 'h0A);
    @(posedge clk);
    hits <= 17'h10000;
    @(posedge clk);
    hits <= '0;
    repeat (4) @(posedge clk);
    #1;
    check({pin_o[0], pin_oe[0]}, 2'b11);
    repeat (6) @(posedge clk);
    #1;
    check({pin_o[0], pin_oe[0]}, 2'b01);
    rd_check('h21);
    report_and_stop();
  end
endmodule // irq_enable_map_softreset_tb
`default_nettype wire

/* File: irq_hold_unit.sv */
// Per-pin hold stage: non-latched, timed or latched interrupt state
`timescale 1ns/10ps
`default_nettype none
module irq_hold_unit
  import irq_map_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic unit_tick,
  input wire logic clear,
  input wire hold_mode_e mode,
  input wire logic [15:0] hold_len,
  // Gated source level and held result
  input wire logic raw,
  output logic active_q
);

  logic [15:0] remain_q;

  // Set wins over clear so an event arriving with the clear is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      remain_q <= 16'h0000;
    end else if (raw) begin
      active_q <= 1'b1;
      remain_q <= hold_len;
    end else begin
      case (mode)
        HOLD_NONE: begin
          active_q <= 1'b0;
          remain_q <= 16'h0000;
        end
        HOLD_TIMED: begin
          if (clear || (unit_tick && remain_q <= 16'h0001)) begin
            active_q <= 1'b0;
            remain_q <= 16'h0000;
          end else if (unit_tick) begin
            remain_q <= remain_q - 16'h0001;
          end
        end
        HOLD_LATCHED: begin
          if (clear) begin
            active_q <= 1'b0;
          end
        end
        default: begin
          active_q <= 1'b0;
          remain_q <= 16'h0000;
        end
      endcase
    end
  end

endmodule // irq_hold_unit
`default_nettype wire

/* File: irq_host_model.sv */
// Host processor model: register port driver and interrupt pin receivers
`timescale 1ns/10ps
`default_nettype none
module irq_host_model (
  // Clock
  input wire logic clk,
  // Register port towards the device
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Pin drivers and resolved line levels
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_line
);
  // Board pull-ups: a released open-drain line reads high, never the last value
  assign pin_line = ~pin_oe | pin_o;
  // Port idle from time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle write strobe; callers pass reserved bits as zero
  // and rewrite their settings after a soft reset
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  // Read strobe, then bounded wait for the answer
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rvalid_q === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata_q;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule // irq_host_model
`default_nettype wire

/* File: irq_map_pkg.sv */
// Constants and carrier types for the interrupt enable, routing and soft-reset block
`default_nettype none
package irq_map_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h14;
  localparam logic [7:0] ADDR_EN_GROUP0 = 8'h16;
  localparam logic [7:0] ADDR_EN_GROUP1 = 8'h17;
  localparam logic [7:0] ADDR_EN_GROUP2 = 8'h18;
  localparam logic [7:0] ADDR_PIN_A_MAP = 8'h19;
  localparam logic [7:0] ADDR_SHARED_MAP = 8'h1A;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h20;
  localparam logic [7:0] ADDR_LATCH_CTRL = 8'h21;

  // Reset values
  localparam logic [7:0] RST_SOFT_RESET = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_MAP = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL = 8'h05;
  localparam logic [7:0] RST_LATCH_CTRL = 8'h00;

  // Soft reset trigger key
  localparam logic [7:0] SOFT_RESET_KEY = 8'hB6;

  // Writable bit masks (reserved bits read as zero)
  localparam logic [7:0] MASK_EN_GROUP0 = 8'hF7;
  localparam logic [7:0] MASK_EN_GROUP1 = 8'h7F;
  localparam logic [7:0] MASK_EN_GROUP2 = 8'h0F;
  localparam logic [7:0] MASK_SHARED_MAP = 8'hE7;
  localparam logic [7:0] MASK_PIN_CTRL = 8'h0F;
  localparam logic [7:0] MASK_LATCH_CTRL = 8'h0F;

  // Field positions in the enable registers
  localparam int EN0_LEVEL_POSE = 7;
  localparam int EN0_POSE_CHANGE = 6;
  localparam int EN0_ONE_KNOCK = 5;
  localparam int EN0_TWO_KNOCK = 4;
  localparam int EN1_QUEUE_MARK = 6;
  localparam int EN1_QUEUE_FULL = 5;
  localparam int EN1_FRESH_SAMPLE = 4;
  localparam int EN1_FREEFALL = 3;
  localparam int EN2_STILL_SEL = 3;
  localparam int AXIS_LSB = 0; // z,y,x at bits 2..0

  // Field positions in the shared map register
  localparam int SMAP_B_FRESH = 7;
  localparam int SMAP_B_MARK = 6;
  localparam int SMAP_B_FULL = 5;
  localparam int SMAP_A_FULL = 2;
  localparam int SMAP_A_MARK = 1;
  localparam int SMAP_A_FRESH = 0;

  // Field positions in the pin and latch control registers
  localparam int PCTL_B_DRAIN = 3;
  localparam int PCTL_B_LEVEL = 2;
  localparam int PCTL_A_DRAIN = 1;
  localparam int PCTL_A_LEVEL = 0;
  localparam int LCTL_CLEAR = 7;

  // Timing: hold timers count in units of the shortest temporary hold
  localparam int CLK_MHZ = 50;
  localparam int HOLD_UNIT_US = 250;
  localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_US * CLK_MHZ;
  localparam int SOFT_RESET_DELAY_US = 2;
  localparam int SOFT_RESET_DELAY_CYCLES = SOFT_RESET_DELAY_US * CLK_MHZ;

  // Number of gated sources; order is that of the pin A map register, then queue sources
  localparam int NUM_SRC = 11;

  typedef enum logic [1:0] {
    HOLD_NONE = 2'b00,
    HOLD_TIMED = 2'b01,
    HOLD_LATCHED = 2'b10
  } hold_mode_e;

  // Event inputs from the detection engines; axis vectors are {z,y,x}
  typedef struct packed {
    logic level_pose;
    logic pose_change;
    logic one_knock;
    logic two_knock;
    logic [2:0] gradient_axes;
    logic [2:0] shock_axes;
    logic freefall;
    logic [2:0] stillness_axes;
    logic queue_mark;
    logic queue_full;
    logic fresh_sample;
  } src_hits_s;

  // Enables handed to the detection engines
  typedef struct packed {
    logic level_pose;
    logic pose_change;
    logic one_knock;
    logic two_knock;
    logic [2:0] gradient_axes;
    logic queue_mark;
    logic queue_full;
    logic fresh_sample;
    logic freefall;
    logic [2:0] shock_axes;
    logic still_no_motion;
    logic [2:0] stillness_axes;
  } engine_cfg_s;

  // Hold length in units of HOLD_UNIT_US for each latch code
  function automatic logic [15:0] hold_units(input logic [3:0] code);
    case (code)
      4'h1: hold_units = 16'h03E8; // 250 ms
      4'h2: hold_units = 16'h07D0; // 500 ms
      4'h3: hold_units = 16'h0FA0; // 1 s
      4'h4: hold_units = 16'h1F40; // 2 s
      4'h5: hold_units = 16'h3E80; // 4 s
      4'h6: hold_units = 16'h7D00; // 8 s
      4'h9: hold_units = 16'h0001; // 250 us
      4'hA: hold_units = 16'h0002; // 500 us
      4'hB: hold_units = 16'h0004; // 1 ms
      4'hC: hold_units = 16'h0032; // 12.5 ms
      4'hD: hold_units = 16'h0064; // 25 ms
      4'hE: hold_units = 16'h00C8; // 50 ms
      default: hold_units = 16'h0000;
    endcase
  endfunction

  function automatic hold_mode_e hold_mode(input logic [3:0] code);
    case (code[2:0])
      3'h0: hold_mode = HOLD_NONE;
      3'h7: hold_mode = HOLD_LATCHED;
      default: hold_mode = HOLD_TIMED;
    endcase
  endfunction

endpackage
`default_nettype wire
